// ==== ecc_pkg.sv ====
// Constants, carriers and check-bit functions for the 64/72 ECC block.
// Assumes one clock domain and an async-assert, sync-release reset.
//
// Behaviour
// - Each 64-bit message becomes a 72-bit codeword.
// - Eight check bits: seven Hamming, one parity.
// - Parity bit covers data and Hamming bits.
// - Check bits above data, parity bit last.
// - Each check bit XORs a fixed subset.
// - Syndrome is recomputed checks XOR received checks.
// - Odd parity means single, even with nonzero syndrome double.
// - 128-bit write splits into two encoded halves.
// - 144-bit read splits into two decoded halves.
// - Encoder has one or two register stages.
// - Read path takes two or three cycles.
// - Encoder loads on enable and ready, holds otherwise.
// - Controls ride matching stages and stall alike.
// - Codeword valid pulses one cycle per codeword.
// - Flags: none, single, double; never both.
// - Check-bit error passes, data-bit error flips.
// - Flags appear with the output valid pulse.
package ecc_pkg;

  // ****************************************************************
  // Widths and layout
  // ****************************************************************
  localparam int MSG_W = 64;
  localparam int HAM_W = 7;
  localparam int CHK_W = 8;
  localparam int CW_W = MSG_W + CHK_W;
  localparam int POS_MAX = MSG_W + HAM_W;
  localparam int LANES = 2;
  localparam int WORD_W = LANES * MSG_W;
  localparam int MEM_W = LANES * CW_W;
  localparam int HAM_LSB = MSG_W;
  localparam int PAR_BIT = CW_W - 1;
  localparam int ADDR_W = 24;
  localparam int SIZE_W = 2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic write_req;
    logic read_req;
    logic burst_begin;
    logic [SIZE_W-1:0] size;
    logic [ADDR_W-1:0] addr;
  } req_ctrl_t;

  typedef struct packed {
    logic double_fault_flag;
    logic single_fault_flag;
  } fault_flags_t;

  // ****************************************************************
  // Check-bit functions
  // ****************************************************************
  // Positions 1..71 that are not powers of two carry the data bits in
  // order; check bit j covers every data position with bit j set.
  function automatic logic [HAM_W-1:0] hamming_checks(
    input logic [MSG_W-1:0] data
  );
    logic [HAM_W-1:0] chk;
    int k;
    chk = '0;
    k = 0;
    for (int p = 1; p <= POS_MAX; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int j = 0; j < HAM_W; j++) begin
          chk[j] = chk[j] ^ (data[k] & p[j]);
        end
        k++;
      end
    end
    return chk;
  endfunction : hamming_checks

  function automatic logic [CW_W-1:0] encode_word(
    input logic [MSG_W-1:0] data
  );
    logic [HAM_W-1:0] chk;
    chk = hamming_checks(data);
    return {^{chk, data}, chk, data};
  endfunction : encode_word

  // A syndrome that names a check-bit position, or no position at all,
  // yields an empty mask, so only data bits are ever flipped.
  function automatic logic [MSG_W-1:0] flip_mask(
    input logic [HAM_W-1:0] syn
  );
    logic [MSG_W-1:0] mask;
    int k;
    mask = '0;
    k = 0;
    for (int p = 1; p <= POS_MAX; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (p[HAM_W-1:0] == syn) begin
          mask[k] = 1'b1;
        end
        k++;
      end
    end
    return mask;
  endfunction : flip_mask

endpackage : ecc_pkg

// ==== ecc_encoder.sv ====
// One 64-bit lane of the write path: encode, then one or two stages.
// Assumes ready comes from logic on the same clock.
module ecc_encoder
  import ecc_pkg::*;
#(
  parameter bit OUT_REG = 1'b1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Message side
  input wire logic [MSG_W-1:0] i_message,
  input wire logic i_enable,
  input wire logic i_ready,
  // Codeword side
  output logic [CW_W-1:0] o_codeword,
  output logic o_valid
);

  logic [CW_W-1:0] s1_cw_q, s1_cw_d, s2_cw_q, s2_cw_d;
  logic s1_val_q, s1_val_d, s2_val_q, s2_val_d;

  // ****************************************************************
  // Stages
  // ****************************************************************
  always_comb begin
    s1_cw_d = s1_cw_q;
    s1_val_d = s1_val_q;
    s2_cw_d = s2_cw_q;
    s2_val_d = 1'b0;
    if (i_ready && i_enable) begin
      s1_cw_d = encode_word(i_message);
    end
    if (i_ready) begin
      s1_val_d = i_enable;
    end else if (!OUT_REG) begin
      s1_val_d = 1'b0;
    end
    if (i_ready && s1_val_q) begin
      s2_cw_d = s1_cw_q;
      s2_val_d = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_cw_q <= '0;
      s1_val_q <= 1'b0;
      s2_cw_q <= '0;
      s2_val_q <= 1'b0;
    end else begin
      s1_cw_q <= s1_cw_d;
      s1_val_q <= s1_val_d;
      s2_cw_q <= s2_cw_d;
      s2_val_q <= s2_val_d;
    end
  end

  assign o_codeword = OUT_REG ? s2_cw_q : s1_cw_q;
  assign o_valid = OUT_REG ? s2_val_q : s1_val_q;

endmodule : ecc_encoder

// ==== ecc_decoder.sv ====
// One 72-bit lane of the read path: optional input stage, detect, correct.
// Assumes the enable is a one-cycle pulse on the same clock.
module ecc_decoder
  import ecc_pkg::*;
#(
  parameter bit IN_REG = 1'b1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Codeword side
  input wire logic [CW_W-1:0] i_codeword,
  input wire logic i_enable,
  // Message side
  output logic [MSG_W-1:0] o_message,
  output logic o_valid,
  output fault_flags_t o_flags
);

  logic [CW_W-1:0] in_cw_q, in_cw_d, cw;
  logic in_val_q, in_val_d, val;
  logic [MSG_W-1:0] d1_msg_q, d1_msg_d, d2_msg_q, d2_msg_d;
  logic [HAM_W-1:0] d1_syn_q, d1_syn_d;
  fault_flags_t d1_flg_q, d1_flg_d, d2_flg_q, d2_flg_d;
  logic d1_val_q, d1_val_d, d2_val_q, d2_val_d;

  // ****************************************************************
  // Detect and correct
  // ****************************************************************
  assign cw = IN_REG ? in_cw_q : i_codeword;
  assign val = IN_REG ? in_val_q : i_enable;

  always_comb begin
    logic odd;
    odd = ^cw;
    in_cw_d = i_codeword;
    in_val_d = i_enable;
    d1_msg_d = cw[MSG_W-1:0];
    d1_syn_d = hamming_checks(cw[MSG_W-1:0]) ^
      cw[HAM_LSB +: HAM_W];
    d1_flg_d.single_fault_flag = odd;
    d1_flg_d.double_fault_flag = !odd && (d1_syn_d != '0);
    d1_val_d = val;
    d2_msg_d = d1_msg_q;
    if (d1_flg_q.single_fault_flag) begin
      d2_msg_d = d1_msg_q ^ flip_mask(d1_syn_q);
    end
    d2_flg_d = d1_flg_q;
    d2_val_d = d1_val_q;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      in_cw_q <= '0;
      in_val_q <= 1'b0;
      d1_msg_q <= '0;
      d1_syn_q <= '0;
      d1_flg_q <= '0;
      d1_val_q <= 1'b0;
      d2_msg_q <= '0;
      d2_flg_q <= '0;
      d2_val_q <= 1'b0;
    end else begin
      in_cw_q <= in_cw_d;
      in_val_q <= in_val_d;
      d1_msg_q <= d1_msg_d;
      d1_syn_q <= d1_syn_d;
      d1_flg_q <= d1_flg_d;
      d1_val_q <= d1_val_d;
      d2_msg_q <= d2_msg_d;
      d2_flg_q <= d2_flg_d;
      d2_val_q <= d2_val_d;
    end
  end

  assign o_message = d2_msg_q;
  assign o_flags = d2_flg_q;
  assign o_valid = d2_val_q;

endmodule : ecc_decoder

// ==== ecc_block.sv ====
// Top of the ECC block between a local bus master and a memory controller.
// Assumes both neighbours run on i_clock and keep their own handshakes.
module ecc_block
  import ecc_pkg::*;
#(
  parameter int ENC_STAGES = 2,
  parameter int DEC_STAGES = 3
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Local write side
  input wire req_ctrl_t i_req,
  input wire logic [WORD_W-1:0] i_wdata,
  output logic o_local_ready,
  // Memory request side
  input wire logic i_mem_ready,
  output req_ctrl_t o_mem_req,
  output logic [MEM_W-1:0] o_mem_wdata,
  output logic o_mem_valid,
  // Memory read side
  input wire logic [MEM_W-1:0] i_mem_rdata,
  input wire logic i_mem_rdata_valid,
  // Local read side
  output logic [WORD_W-1:0] o_rdata,
  output logic o_rdata_valid,
  output fault_flags_t o_flags_lo,
  output fault_flags_t o_flags_hi
);

  localparam bit ENC_OUT_REG = (ENC_STAGES == 2);
  localparam bit DEC_IN_REG = (DEC_STAGES == 3);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ENC_STAGES < 1 || ENC_STAGES > 2) begin : g_bad_enc
    $error("ENC_STAGES must be 1 or 2");
  end
  if (DEC_STAGES < 2 || DEC_STAGES > 3) begin : g_bad_dec
    $error("DEC_STAGES must be 2 or 3");
  end

  // ****************************************************************
  // Request enable and local ready
  // ****************************************************************
  // The encoder runs for every request so that read requests keep
  // their place in the same pipeline as writes.
  logic enc_enable;
  logic ready_q, ready_d;
  logic [LANES-1:0] enc_valid;
  logic [LANES-1:0] dec_valid;
  logic [MSG_W-1:0] dec_msg [LANES];
  fault_flags_t dec_flags [LANES];

  assign enc_enable = i_req.write_req | i_req.read_req;

  // Local ready mirrors the controller's ready one cycle late, because
  // the output must come from a register. A request raised in the cycle
  // after ready falls is still dropped, so this copy is only a hint.
  always_comb begin
    ready_d = i_mem_ready;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
    end
  end

  assign o_local_ready = ready_q;

  // ****************************************************************
  // Write path lanes
  // ****************************************************************
  for (genvar g = 0; g < LANES; g++) begin : g_enc
    ecc_encoder #(
      .OUT_REG(ENC_OUT_REG)
    ) u_enc (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_message(i_wdata[g*MSG_W +: MSG_W]),
      .i_enable(enc_enable),
      .i_ready(i_mem_ready),
      .o_codeword(o_mem_wdata[g*CW_W +: CW_W]),
      .o_valid(enc_valid[g])
    );
  end

  // Both lanes share one enable and one ready, so lane 0 speaks for both.
  assign o_mem_valid = enc_valid[0];

  // ****************************************************************
  // Control pipeline
  // ****************************************************************
  req_ctrl_t c1_q, c1_d, c2_q, c2_d;

  always_comb begin
    c1_d = c1_q;
    c2_d = c2_q;
    if (i_mem_ready && enc_enable) begin
      c1_d = i_req;
    end
    if (i_mem_ready) begin
      c2_d = c1_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      c1_q <= '0;
      c2_q <= '0;
    end else begin
      c1_q <= c1_d;
      c2_q <= c2_d;
    end
  end

  assign o_mem_req = ENC_OUT_REG ? c2_q : c1_q;

  // ****************************************************************
  // Read path lanes
  // ****************************************************************
  for (genvar g = 0; g < LANES; g++) begin : g_dec
    ecc_decoder #(
      .IN_REG(DEC_IN_REG)
    ) u_dec (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_codeword(i_mem_rdata[g*CW_W +: CW_W]),
      .i_enable(i_mem_rdata_valid),
      .o_message(dec_msg[g]),
      .o_valid(dec_valid[g]),
      .o_flags(dec_flags[g])
    );
    assign o_rdata[g*MSG_W +: MSG_W] = dec_msg[g];
  end

  assign o_rdata_valid = dec_valid[0];
  assign o_flags_lo = dec_flags[0];
  assign o_flags_hi = dec_flags[1];

endmodule : ecc_block

// ==== ecc_block_checker.sv ====
// Concurrent checks on the ports of the ECC block top.
// Assumes one clock domain; bound to every ecc_block instance.
module ecc_block_checker
  import ecc_pkg::*;
#(
  parameter int ENC_STAGES = 2,
  parameter int DEC_STAGES = 3
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Write side
  input wire req_ctrl_t i_req,
  input wire logic [WORD_W-1:0] i_wdata,
  input wire logic o_local_ready,
  input wire logic i_mem_ready,
  input wire req_ctrl_t o_mem_req,
  input wire logic [MEM_W-1:0] o_mem_wdata,
  input wire logic o_mem_valid,
  // Read side
  input wire logic [MEM_W-1:0] i_mem_rdata,
  input wire logic i_mem_rdata_valid,
  input wire logic [WORD_W-1:0] o_rdata,
  input wire logic o_rdata_valid,
  input wire fault_flags_t o_flags_lo,
  input wire fault_flags_t o_flags_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // Properties
  // ********************************
  localparam int EL = ENC_STAGES - 1;
  localparam int DL = DEC_STAGES;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  property p_enc_lat;
    (i_req.write_req | i_req.read_req) && i_mem_ready ##1 i_mem_ready
      |-> ##[EL:EL] o_mem_valid;
  endproperty
  a_enc_lat: assert property (p_enc_lat) else $error("enc late");
  property p_par_lo;
    o_mem_valid |-> !(^o_mem_wdata[CW_W-1:0]);
  endproperty
  a_par_lo: assert property (p_par_lo) else $error("lane 0 odd");
  property p_par_hi;
    o_mem_valid |-> !(^o_mem_wdata[MEM_W-1:CW_W]);
  endproperty
  a_par_hi: assert property (p_par_hi) else $error("lane 1 odd");
  property p_stall;
    !i_mem_ready |=> $stable(o_mem_wdata) && $stable(o_mem_req)
      && !o_mem_valid;
  endproperty
  a_stall: assert property (p_stall) else $error("moved in stall");
  property p_ctrl;
    o_mem_valid |-> o_mem_req.write_req || o_mem_req.read_req;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("no request");
  property p_pulse;
    o_mem_valid |-> $past(i_mem_ready);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse in stall");
  property p_dec_lat;
    i_mem_rdata_valid |-> ##[DL:DL] o_rdata_valid;
  endproperty
  a_dec_lat: assert property (p_dec_lat) else $error("read late");
  property p_excl;
    o_rdata_valid |->
      !(o_flags_lo.single_fault_flag && o_flags_lo.double_fault_flag)
      && !(o_flags_hi.single_fault_flag && o_flags_hi.double_fault_flag);
  endproperty
  a_excl: assert property (p_excl) else $error("both flags");
  property p_odd;
    i_mem_rdata_valid && ^i_mem_rdata[CW_W-1:0]
      |-> ##[DL:DL] o_rdata_valid && o_flags_lo.single_fault_flag;
  endproperty
  a_odd: assert property (p_odd) else $error("odd not single");
endmodule : ecc_block_checker

bind ecc_block ecc_block_checker #(.ENC_STAGES(ENC_STAGES),
  .DEC_STAGES(DEC_STAGES)) ecc_block_checker_inst (.i_clock(i_clock),
  .i_rstn(i_rstn), .i_req(i_req), .i_wdata(i_wdata),
  .o_local_ready(o_local_ready), .i_mem_ready(i_mem_ready),
  .o_mem_req(o_mem_req), .o_mem_wdata(o_mem_wdata),
  .o_mem_valid(o_mem_valid), .i_mem_rdata(i_mem_rdata),
  .i_mem_rdata_valid(i_mem_rdata_valid), .o_rdata(o_rdata),
  .o_rdata_valid(o_rdata_valid), .o_flags_lo(o_flags_lo),
  .o_flags_hi(o_flags_hi));

// ==== ecc_mem_model.sv ====
// Memory controller model: random ready, one stored word, read back.
// Assumes the bench sets the flip mask and the read strobe.
module ecc_mem_model
  import ecc_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Bench control
  input wire logic i_slow,
  input wire logic i_go,
  input wire logic [MEM_W-1:0] i_flip,
  // Block side
  input wire logic [MEM_W-1:0] i_wdata,
  input wire logic i_valid,
  output logic o_ready,
  output logic [MEM_W-1:0] o_rdata,
  output logic o_rdata_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [MEM_W-1:0] mem_q;
  // Idle read data toggles so a stale word is never mistaken for fresh.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ready <= 1'b0;
      o_rdata <= '0;
      o_rdata_valid <= 1'b0;
      mem_q <= '0;
    end else begin
      o_ready <= !i_slow || ($urandom_range(3) != 0);
      if (i_valid) begin
        mem_q <= i_wdata;
      end
      o_rdata_valid <= i_go;
      o_rdata <= i_go ? (mem_q ^ i_flip) : ~o_rdata;
    end
  end
endmodule : ecc_mem_model

// ==== ecc_block_tb_top.sv ====
// Self-checking bench for the ECC block with a memory model.
// Assumes default stage counts and a 40 MHz clock.
module ecc_block_tb_top
  import ecc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock;
  logic i_rstn;
  req_ctrl_t i_req;
  req_ctrl_t mem_req;
  req_ctrl_t wreq;
  logic [WORD_W-1:0] i_wdata;
  logic [WORD_W-1:0] wd;
  logic [WORD_W-1:0] rdata;
  logic [MEM_W-1:0] mem_wdata;
  logic [MEM_W-1:0] mem_rdata;
  logic [MEM_W-1:0] flip;
  logic mem_ready;
  logic mem_valid;
  logic mem_rvalid;
  logic rvalid;
  logic slow;
  logic go;
  logic local_ready;
  logic ready_prev;
  fault_flags_t flags_lo;
  fault_flags_t flags_hi;
  logic [$bits(req_ctrl_t)+WORD_W-1:0] q[$];
  logic [$bits(req_ctrl_t)+WORD_W-1:0] e;
  int bad_count;
  int n_checks;

  ecc_block ecc_block_inst (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_req(i_req), .i_wdata(i_wdata), .o_local_ready(local_ready),
    .i_mem_ready(mem_ready), .o_mem_req(mem_req), .o_mem_wdata(mem_wdata),
    .o_mem_valid(mem_valid), .i_mem_rdata(mem_rdata),
    .i_mem_rdata_valid(mem_rvalid), .o_rdata(rdata), .o_rdata_valid(rvalid),
    .o_flags_lo(flags_lo), .o_flags_hi(flags_hi));
  ecc_mem_model ecc_mem_model_inst (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_slow(slow), .i_go(go), .i_flip(flip), .i_wdata(mem_wdata),
    .i_valid(mem_valid), .o_ready(mem_ready), .o_rdata(mem_rdata),
    .o_rdata_valid(mem_rvalid));

  // ********************************
  // Expectations and tasks
  // ********************************
  function automatic logic [CW_W-1:0] enc(input logic [MSG_W-1:0] d);
    logic [HAM_W-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p < CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int j = 0; j < HAM_W; j++) begin
          c[j] = c[j] ^ (d[k] & p[j]);
        end
        k++;
      end
    end
    return {^{c, d}, c, d};
  endfunction : enc

  // Three or more flips alias onto fewer, so only zero to two are used.
  function automatic logic [65:0] xl(input logic [63:0] d,
                                     input logic [71:0] f);
    int n;
    n = $countones(f);
    if (n == 0) return {2'b00, d};
    if (n == 1) return {2'b01, d};
    return {2'b10, d ^ f[63:0]};
  endfunction : xl

  function automatic logic [71:0] mkf(input int k);
    int a;
    logic [71:0] m;
    a = $urandom_range(63);
    m = '0;
    case (k)
      1: m[a] = 1'b1;
      2: m[64 + a % 7] = 1'b1;
      3: m[71] = 1'b1;
      4: begin
        m[a] = 1'b1;
        m[(a + 1 + $urandom_range(70)) % 72] = 1'b1;
      end
      default: m = '0;
    endcase
    return m;
  endfunction : mkf

  task automatic chk(input string nm, input logic [MEM_W-1:0] x,
                     input logic [MEM_W-1:0] g);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic wr(input logic [WORD_W-1:0] d, input req_ctrl_t r);
    i_wdata = d;
    i_req = r;
    @(posedge i_clock);
    while (mem_ready !== 1'b1) @(posedge i_clock);
    #2;
  endtask : wr

  task automatic drain;
    for (int t = 0; t < 40 && q.size() > 0; t++) @(posedge i_clock);
    @(posedge i_clock);
    #2;
  endtask : drain

  task automatic rd(input logic [WORD_W-1:0] d, input logic [MEM_W-1:0] f);
    logic [65:0] lo;
    logic [65:0] hi;
    req_ctrl_t r;
    r = '0;
    r.write_req = 1'b1;
    r.addr = ADDR_W'($urandom);
    wr(d, r);
    i_req = '0;
    drain();
    go = 1'b1;
    flip = f;
    @(posedge i_clock);
    #2;
    go = 1'b0;
    for (int t = 0; t < 6 && rvalid !== 1'b1; t++) begin
      @(posedge i_clock);
      #2;
    end
    chk("rdata_valid", 1, rvalid);
    lo = xl(d[63:0], f[71:0]);
    hi = xl(d[127:64], f[143:72]);
    chk("rdata", {hi[63:0], lo[63:0]}, rdata);
    chk("flags_lo", lo[65:64], flags_lo);
    chk("flags_hi", hi[65:64], flags_hi);
    @(posedge i_clock);
    #2;
    chk("rdata_valid_end", 0, rvalid);
  endtask : rd

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // ********************************
  // Clock, monitor and sequence
  // ********************************
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  initial begin
    #75000;
    bad_count++;
    tally_and_finish();
  end

  always @(posedge i_clock) begin
    if (i_rstn === 1'b1) begin
      chk("local_ready", ready_prev, local_ready);
    end
    ready_prev = mem_ready;
    if (i_rstn === 1'b1 && (i_req.write_req | i_req.read_req)
        && mem_ready === 1'b1) begin
      q.push_back({i_req, i_wdata});
    end
    if (mem_valid === 1'b1) begin
      if (q.size() > 0) begin
        e = q.pop_front();
        chk("mem_wdata", {enc(e[127:64]), enc(e[63:0])},
          mem_wdata);
        chk("mem_req", e[WORD_W +: $bits(req_ctrl_t)], mem_req);
      end else begin
        chk("mem_valid", 0, 1);
      end
    end
  end

  initial begin
    void'($urandom(52));
    i_rstn = 1'b0;
    i_req = '0;
    i_wdata = '0;
    slow = 1'b1;
    go = 1'b0;
    flip = '0;
    bad_count = 0;
    n_checks = 0;
    repeat (2) @(posedge i_clock);
    #2 i_rstn = 1'b1;
    for (int i = 0; i < 40; i++) begin
      slow = (i < 24);
      wreq = '0;
      wreq.write_req = ($urandom_range(3) != 0);
      wreq.read_req = !wreq.write_req;
      wreq.burst_begin = 1'($urandom);
      wreq.size = SIZE_W'($urandom);
      wreq.addr = ADDR_W'($urandom);
      wd = (i == 0) ? '0 : (i == 1) ? '1 :
        {$urandom, $urandom, $urandom, $urandom};
      wr(wd, wreq);
    end
    i_req = '0;
    drain();
    chk("pending", 0, q.size());
    slow = 1'b1;
    for (int i = 0; i < 15; i++) begin
      wd = {$urandom, $urandom, $urandom, $urandom};
      rd(wd, {mkf((i + 2) % 5), mkf(i % 5)});
    end
    tally_and_finish();
  end
endmodule : ecc_block_tb_top
